// File: tb/orm_exec_tb_top.sv
// self-checking bench for the or/move/pointer-load executor
`timescale 1ns/10ps
`include "orm_regs.svh"
module orm_exec_tb_top;
	import orm_pkg::*;
	logic        mclk;
	logic        rst_n;
	logic        ce;
	logic        wb_cyc_i;
	logic        wb_stb_i;
	logic        wb_we_i;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	int          mismatches;
	int          n_compared;
	logic [11:0] kval [3];

	orm_exec DUT (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.ce       (ce),
		.wb_cyc_i (wb_cyc_i),
		.wb_stb_i (wb_stb_i),
		.wb_we_i  (wb_we_i),
		.wb_adr_i (wb_adr_i),
		.wb_sel_i (wb_sel_i),
		.wb_dat_i (wb_dat_i),
		.wb_dat_o (wb_dat_o),
		.wb_ack_o (wb_ack_o)
	);

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// one classic cycle; ack and read data sampled at the same edge
	task automatic wb(input logic we, input logic [7:0] adr,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge mclk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_sel_i <= 4'hF;
		wb_adr_i <= adr;
		wb_dat_i <= d;
		do begin
			@(posedge mclk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			mismatches++;
			wrap_up();
		end
	endtask : wb

	task automatic wr(input logic [7:0] adr, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, adr, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, adr, 32'h0000_0000, q);
		chk(q, exp);
	endtask : rd

	// status reads never stall, so completion is polled, not assumed
	task automatic ex(input logic [15:0] ins);
		logic [31:0] q;
		int n;
		wb(1'b1, `ORM_OFF_INSTR, {16'h0000, ins}, q);
		n = 0;
		do begin
			wb(1'b0, `ORM_OFF_STATUS, 32'h0000_0000, q);
			n++;
		end while (q[`ORM_ST_BUSY_BIT] !== 1'b0 && n < 20);
		if (q[`ORM_ST_BUSY_BIT] !== 1'b0) begin
			mismatches++;
			wrap_up();
		end
	endtask : ex

	task automatic poke(input logic [11:0] a, input logic [7:0] d);
		wr(`ORM_OFF_MADDR, {20'h00000, a});
		wr(`ORM_OFF_MDATA, {24'h000000, d});
	endtask : poke

	task automatic peek(input logic [11:0] a, input logic [7:0] d);
		wr(`ORM_OFF_MADDR, {20'h00000, a});
		rd(`ORM_OFF_MDATA, {24'h000000, d});
	endtask : peek

	initial begin
		rst_n    = 1'b0;
		ce       = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i  = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0000_0000;
		mismatches = 0;
		n_compared = 0;
		kval = '{12'hFFF, 12'h0A5, 12'h3AB};
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		rd(`ORM_OFF_WORK, 32'h0000_0000);
		rd(`ORM_OFF_STATUS, 32'h0000_0000);
		rd(`ORM_OFF_PTR2, 32'h0000_0000);
		wr(8'hF0, 32'h0000_00FF);
		rd(8'hF0, 32'h0000_0000);
		// literal or: 9A | 35 = BF, negative
		wr(`ORM_OFF_WORK, 32'h0000_009A);
		ex(16'h0935);
		rd(`ORM_OFF_WORK, 32'h0000_00BF);
		rd(`ORM_OFF_STATUS, 32'h0000_0004);
		wr(`ORM_OFF_WORK, 32'h0000_0000);
		ex(16'h0900);
		rd(`ORM_OFF_STATUS, 32'h0000_0002);
		// banked or at the top of bank 3, both destinations
		wr(`ORM_OFF_BANK, 32'h0000_0003);
		poke(12'h3FF, 8'h13);
		wr(`ORM_OFF_WORK, 32'h0000_0091);
		ex(16'h11FF);
		rd(`ORM_OFF_WORK, 32'h0000_0093);
		rd(`ORM_OFF_STATUS, 32'h0000_0004);
		wr(`ORM_OFF_WORK, 32'h0000_0040);
		ex(16'h13FF);
		rd(`ORM_OFF_WORK, 32'h0000_0040);
		peek(12'h3FF, 8'h53);
		// quick-access bank ignores the bank value
		wr(`ORM_OFF_BANK, 32'h0000_0005);
		poke(12'hF70, 8'h00);
		ex(16'h5070);
		rd(`ORM_OFF_WORK, 32'h0000_0000);
		rd(`ORM_OFF_STATUS, 32'h0000_0002);
		poke(12'hFA0, 8'h80);
		ex(16'h50A0);
		rd(`ORM_OFF_WORK, 32'h0000_0080);
		poke(12'h05F, 8'h21);
		ex(16'h505F);
		rd(`ORM_OFF_WORK, 32'h0000_0021);
		// pointer loads must leave the zero flag alone
		wr(`ORM_OFF_WORK, 32'h0000_0000);
		ex(16'h0900);
		for (int f = 0; f < 3; f++) begin
			ex({8'hE0, 2'b00, 2'(f), kval[f][11:8]});
			rd(`ORM_OFF_STATUS, 32'h0000_000A);
			ex({8'hF0, kval[f][7:0]});
			rd(`ORM_OFF_PTR0 + 8'(4 * f), {20'h00000, kval[f]});
			rd(`ORM_OFF_STATUS, 32'h0000_0002);
		end
		// indexed offset: pointer 2 (3AB) plus 10 -> 3BB
		wr(`ORM_OFF_CTRL, 32'h0000_0001);
		poke(12'h3BB, 8'h7E);
		ex(16'h5010);
		rd(`ORM_OFF_WORK, 32'h0000_007E);
		poke(12'hF60, 8'hC3);
		ex(16'h5060);
		rd(`ORM_OFF_WORK, 32'h0000_00C3);
		rd(`ORM_OFF_STATUS, 32'h0000_0004);
		// ce low mid-op must freeze the phase, so busy outlives 4 cycles
		wr(`ORM_OFF_INSTR, 32'h0000_093C);
		ce <= 1'b0;
		repeat (8) @(posedge mclk);
		ce <= 1'b1;
		rd(`ORM_OFF_STATUS, 32'h0000_0005);
		rd(`ORM_OFF_WORK, 32'h0000_00FF);
		rd(`ORM_OFF_STATUS, 32'h0000_0004);
		wrap_up();
	end
endmodule : orm_exec_tb_top

// File: verilog/orm_exec.sv
// or/move/pointer-load executor with a classic wishbone register slave
`timescale 1ns/10ps
`include "orm_regs.svh"
module orm_exec (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o
);
	import orm_pkg::*;

	orm_phase_t ph_q;
	orm_dec_t   dec;
	logic [15:0] ir_q;
	logic [7:0]  w_q, res_q, mem_rdata, mem_wdata;
	logic [3:0]  bsr_q;
	logic [11:0] ptr_q [0:2];
	logic [11:0] maddr_q, eff, mem_addr;
	logic [1:0]  psel_q;
	logic        ext_q, z_q, n_q, ld_wait_q, ack_q, mrd_pend_q;
	logic        busy, req, mrd, stall, acc_go, mrd_issue, start, file_op;
	logic        mem_en, mem_we, core_rd, core_wr, bus_mwr;
	logic [31:0] dat_d;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// wishbone slave; writes and ram reads wait while an op runs
	assign busy      = (ph_q != ORM_IDLE);
	assign req       = wb_cyc_i & wb_stb_i;
	assign mrd       = !wb_we_i && (wb_adr_i == `ORM_OFF_MDATA);
	assign stall     = busy & (wb_we_i | mrd);
	assign mrd_issue = req & mrd & ~stall & ~ack_q & ~mrd_pend_q;
	assign acc_go    = req & ~ack_q & ~stall & (~mrd | mrd_pend_q);
	assign start     = acc_go && wb_we_i && (wb_adr_i == `ORM_OFF_INSTR)
			&& (wb_sel_i[1:0] == 2'h3);
	assign bus_mwr   = acc_go && wb_we_i && (wb_adr_i == `ORM_OFF_MDATA)
			&& wb_sel_i[0];
	assign wb_ack_o  = ack_q;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ack_q      <= 1'b0;
			mrd_pend_q <= 1'b0;
		end else if (ce) begin
			ack_q      <= acc_go;
			mrd_pend_q <= mrd_issue | (mrd_pend_q & ~acc_go);
		end
	end

	always_comb begin
		dat_d = 32'h0000_0000;
		case (wb_adr_i)
			`ORM_OFF_INSTR:  dat_d[15:0] = ir_q;
			`ORM_OFF_CTRL:   dat_d[`ORM_CTRL_EXT_BIT] = ext_q;
			`ORM_OFF_STATUS: dat_d[3:0] = {ld_wait_q, n_q, z_q, busy};
			`ORM_OFF_WORK:   dat_d[7:0] = w_q;
			`ORM_OFF_BANK:   dat_d[3:0] = bsr_q;
			`ORM_OFF_PTR0:   dat_d[11:0] = ptr_q[0];
			`ORM_OFF_PTR1:   dat_d[11:0] = ptr_q[1];
			`ORM_OFF_PTR2:   dat_d[11:0] = ptr_q[2];
			`ORM_OFF_MADDR:  dat_d[11:0] = maddr_q;
			`ORM_OFF_MDATA:  dat_d[7:0] = mem_rdata;
			default:         dat_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wb_dat_o <= `ORM_RST_WORD;
		end else if (ce && acc_go && !wb_we_i) begin
			wb_dat_o <= dat_d;
		end
	end

	// software-written state; only bus writes change these registers, ops never do
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ir_q    <= `ORM_RST_IR;
			ext_q   <= 1'b0;
			bsr_q   <= `ORM_RST_BANK;
			maddr_q <= `ORM_RST_ADDR;
		end else if (ce && acc_go && wb_we_i) begin
			if (start) begin
				ir_q <= wb_dat_i[15:0];
			end
			if (wb_sel_i[0]) begin
				case (wb_adr_i)
					`ORM_OFF_CTRL:  ext_q <= wb_dat_i[`ORM_CTRL_EXT_BIT];
					`ORM_OFF_BANK:  bsr_q <= wb_dat_i[3:0];
					`ORM_OFF_MADDR: maddr_q[7:0] <= wb_dat_i[7:0];
					default:        ;
				endcase
			end
			if (wb_sel_i[1] && wb_adr_i == `ORM_OFF_MADDR) begin
				maddr_q[11:8] <= wb_dat_i[11:8];
			end
		end
	end

	// decode; a pending pointer load takes the next word as its low byte
	always_comb begin
		dec      = '0;
		dec.op   = OP_NONE;
		dec.dest = ir_q[`ORM_DEST_BIT];
		dec.acc  = ir_q[`ORM_ACC_BIT];
		dec.fa   = ir_q[7:0];
		dec.lit  = ir_q[7:0];
		dec.psel = ir_q[5:4];
		if (ld_wait_q) begin
			dec.op = OP_LD_LO;
		end else if (ir_q[15:8] == `ORM_OP_OR_LIT) begin
			dec.op = OP_OR_LIT;
		end else if (ir_q[15:10] == `ORM_OP_OR_FILE) begin
			dec.op = OP_OR_FILE;
		end else if (ir_q[15:10] == `ORM_OP_COPY) begin
			dec.op = OP_COPY;
		end else if (ir_q[15:10] == `ORM_OP_LDPTR
				&& ir_q[5:4] != `ORM_BAD_PTR) begin
			dec.op = OP_LD_HI;
		end
	end
	assign file_op = (dec.op == OP_OR_FILE) || (dec.op == OP_COPY);

	// effective address: banked, quick-access, or pointer-indexed
	always_comb begin
		if (dec.acc) begin
			eff = {bsr_q, dec.fa};
		end else if (ext_q && dec.fa <= `ORM_ILO_MAX) begin
			eff = ptr_q[`ORM_ILO_PTR] + {4'h0, dec.fa};
		end else if (dec.fa < `ORM_ACC_SPLIT) begin
			eff = {`ORM_ACC_LO, dec.fa};
		end else begin
			eff = {`ORM_ACC_HI, dec.fa};
		end
	end

	// ram port: core owns it while busy, bus only when idle
	assign core_rd   = (ph_q == ORM_Q2) && file_op;
	assign core_wr   = (ph_q == ORM_Q4) && file_op && dec.dest;
	assign mem_en    = core_rd | core_wr | mrd_issue | bus_mwr;
	assign mem_we    = core_wr | bus_mwr;
	assign mem_addr  = busy ? eff : maddr_q;
	assign mem_wdata = busy ? res_q : wb_dat_i[7:0];

	orm_ram u_ram (
		.mclk  (mclk),
		.rst_n (rst_n),
		.ce    (ce),
		.en    (mem_en),
		.we    (mem_we),
		.addr  (mem_addr),
		.wdata (mem_wdata),
		.rdata (mem_rdata)
	);

	// four phases: decode, operand read, process, destination write
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ph_q <= ORM_IDLE;
		end else if (ce) begin
			case (ph_q)
				ORM_IDLE: if (start) begin
					ph_q <= ORM_Q1;
				end
				ORM_Q1:   ph_q <= ORM_Q2;
				ORM_Q2:   ph_q <= ORM_Q3;
				ORM_Q3:   ph_q <= ORM_Q4;
				default:  ph_q <= ORM_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			res_q <= `ORM_RST_BYTE;
		end else if (ce && ph_q == ORM_Q3) begin
			case (dec.op)
				OP_OR_LIT:  res_q <= w_q | dec.lit;
				OP_OR_FILE: res_q <= w_q | mem_rdata;
				OP_COPY:    res_q <= mem_rdata;
				default:    res_q <= res_q;
			endcase
		end
	end

	// work and flags; bus writes cannot collide since they stall while busy
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			w_q <= `ORM_RST_BYTE;
			z_q <= 1'b0;
			n_q <= 1'b0;
		end else if (ce) begin
			if (ph_q == ORM_Q4 && (dec.op == OP_OR_LIT || file_op)) begin
				z_q <= (res_q == 8'h00);
				n_q <= res_q[7];
				if (dec.op == OP_OR_LIT || !dec.dest) begin
					w_q <= res_q;
				end
			end else if (acc_go && wb_we_i && wb_sel_i[0]
					&& wb_adr_i == `ORM_OFF_WORK) begin
				w_q <= wb_dat_i[7:0];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ld_wait_q <= 1'b0;
			psel_q    <= 2'h0;
		end else if (ce && ph_q == ORM_Q4) begin
			if (dec.op == OP_LD_HI) begin
				ld_wait_q <= 1'b1;
				psel_q    <= dec.psel;
			end else if (dec.op == OP_LD_LO) begin
				ld_wait_q <= 1'b0;
			end
		end
	end

	for (genvar g = 0; g < `ORM_NUM_PTR; g++) begin : g_ptr
		always_ff @(posedge mclk) begin
			if (!rst_n) begin
				ptr_q[g] <= `ORM_RST_PTR;
			end else if (ce && ph_q == ORM_Q4) begin
				if (dec.op == OP_LD_HI && dec.psel == 2'(g)) begin
					ptr_q[g][11:8] <= dec.lit[3:0];
				end
				if (dec.op == OP_LD_LO && psel_q == 2'(g)) begin
					ptr_q[g][7:0] <= dec.lit;
				end
			end
		end
	end

	property p_or_lit;
		(ce && ph_q == ORM_Q4 && dec.op == OP_OR_LIT)
			|=> (w_q == ($past(res_q))) && (z_q == ($past(res_q) == 8'h00));
	endproperty
	a_or_lit: assert property (p_or_lit) else $error("or literal wrong");

	property p_or_file;
		(ce && ph_q == ORM_Q3 && dec.op == OP_OR_FILE)
			|=> res_q == ($past(w_q) | $past(mem_rdata));
	endproperty
	a_or_file: assert property (p_or_file) else $error("or file wrong");

	property p_dest;
		(ce && ph_q == ORM_Q4 && file_op && dec.dest)
			|-> mem_we && mem_en && mem_wdata == res_q && mem_addr == eff;
	endproperty
	a_dest: assert property (p_dest) else $error("file writeback wrong");

	property p_bank;
		(ph_q == ORM_Q2 && file_op && dec.acc)
			|-> mem_en && !mem_we && mem_addr == {bsr_q, dec.fa};
	endproperty
	a_bank: assert property (p_bank) else $error("banked address wrong");

	property p_ilo;
		(ph_q == ORM_Q2 && file_op && !dec.acc && ext_q
			&& dec.fa <= `ORM_ILO_MAX)
			|-> mem_addr == ptr_q[2] + {4'h0, dec.fa};
	endproperty
	a_ilo: assert property (p_ilo) else $error("indexed address wrong");

	property p_ld_flags;
		(ce && ph_q == ORM_Q4 && (dec.op == OP_LD_HI || dec.op == OP_LD_LO))
			|=> $stable(z_q) && $stable(n_q);
	endproperty
	a_ld_flags: assert property (p_ld_flags) else $error("flag changed");

	property p_copy;
		(ce && ph_q == ORM_Q3 && dec.op == OP_COPY)
			|=> res_q == $past(mem_rdata);
	endproperty
	a_copy: assert property (p_copy) else $error("copy wrong");

	property p_phases;
		(start && ce) ##1 ce [*3] |=> ph_q == ORM_Q4;
	endproperty
	a_phases: assert property (p_phases) else $error("phase count off");

	property p_ld_hi;
		(ce && ph_q == ORM_Q4 && dec.op == OP_LD_HI)
			|=> ld_wait_q && ptr_q[psel_q][11:8] == $past(ir_q[3:0]);
	endproperty
	a_ld_hi: assert property (p_ld_hi) else $error("pointer high wrong");

	c_or_lit: cover property (ce && ph_q == ORM_Q4 && dec.op == OP_OR_LIT);
	c_ilo: cover property (ph_q == ORM_Q2 && file_op && !dec.acc && ext_q);
	c_ld_lo: cover property (ce && ph_q == ORM_Q4 && dec.op == OP_LD_LO);
endmodule : orm_exec

// File: verilog/orm_pkg.sv
// types shared by the or/move executor
package orm_pkg;
	typedef enum logic [2:0] {
		ORM_IDLE, ORM_Q1, ORM_Q2, ORM_Q3, ORM_Q4
	} orm_phase_t;
	typedef enum logic [2:0] {
		OP_NONE, OP_OR_LIT, OP_OR_FILE, OP_COPY, OP_LD_HI, OP_LD_LO
	} orm_op_t;
	typedef struct packed {
		orm_op_t    op;
		logic       dest;
		logic       acc;
		logic [7:0] fa;
		logic [7:0] lit;
		logic [1:0] psel;
	} orm_dec_t;
endpackage : orm_pkg

// File: verilog/orm_ram.sv
// general purpose data ram, 4096 bytes, registered read
`timescale 1ns/10ps
module orm_ram (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic        en,
	input  wire logic        we,
	input  wire logic [11:0] addr,
	input  wire logic [7:0]  wdata,
	output logic      [7:0]  rdata
);
	logic [7:0] mem_q [0:4095];

	always_ff @(posedge mclk) begin
		if (ce && en && we) begin
			mem_q[addr] <= wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else if (ce && en && !we) begin
			rdata <= mem_q[addr];
		end
	end
endmodule : orm_ram

// File: verilog/orm_regs.svh
// register offsets, fields, reset values and opcodes of the or/move executor
`ifndef ORM_REGS_SVH
`define ORM_REGS_SVH
// Functional notes
// - Opcode 0000 1001 plus literal ORs the literal into work, setting N/Z.
// - Opcode 0001 00da ORs work with the file register, setting N/Z.
// - Destination bit 0 sends the result to work, 1 back to the file.
// - Access bit 0 uses the quick-access bank, 1 uses the bank select value.
// - Access 0, extended set on and address up to 5Fh use pointer 2 plus f.
// - Pointer load 1110 00xx xxff kkkk writes a 12-bit literal to pointer 0..2, no flag.
// - Opcode 0101 00da copies the file register to the destination, N/Z.
// - The 8-bit file address reaches all of the selected 256-byte bank.
`define ORM_OFF_INSTR 8'h00
`define ORM_OFF_CTRL 8'h04
`define ORM_OFF_STATUS 8'h08
`define ORM_OFF_WORK 8'h0C
`define ORM_OFF_BANK 8'h10
`define ORM_OFF_PTR0 8'h14
`define ORM_OFF_PTR1 8'h18
`define ORM_OFF_PTR2 8'h1C
`define ORM_OFF_MADDR 8'h20
`define ORM_OFF_MDATA 8'h24
`define ORM_CTRL_EXT_BIT 0
`define ORM_ST_BUSY_BIT 0
`define ORM_ST_Z_BIT 1
`define ORM_ST_N_BIT 2
`define ORM_ST_WAIT_BIT 3
`define ORM_DEST_BIT 9
`define ORM_ACC_BIT 8
`define ORM_OP_OR_LIT 8'h09
`define ORM_OP_OR_FILE 6'h04
`define ORM_OP_COPY 6'h14
`define ORM_OP_LDPTR 6'h38
`define ORM_BAD_PTR 2'h3
`define ORM_ILO_MAX 8'h5F
`define ORM_ACC_SPLIT 8'h60
`define ORM_ACC_LO 4'h0
`define ORM_ACC_HI 4'hF
`define ORM_ILO_PTR 2
`define ORM_NUM_PTR 3
`define ORM_RST_BYTE 8'h00
`define ORM_RST_BANK 4'h0
`define ORM_RST_PTR 12'h000
`define ORM_RST_IR 16'h0000
`define ORM_RST_ADDR 12'h000
`define ORM_RST_WORD 32'h0000_0000
`endif
